// *** core/dc_latch_pkg.sv ***
// Constants, types and decoding shared by the latch timestamp capture block
package dc_latch_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [15:0] LATCH_A_RISE_OFS = 16'h09b0;
  localparam logic [15:0] LATCH_A_FALL_OFS = 16'h09b8;
  localparam logic [15:0] LATCH_B_RISE_OFS = 16'h09c0;
  localparam logic [15:0] LATCH_B_FALL_OFS = 16'h09c8;
  localparam logic [15:0] LATCH_LAST_OFS   = 16'h09cf;
  localparam logic [15:0] FB_CHANGE_OFS    = 16'h09f0;
  localparam logic [15:0] HOST_START_OFS   = 16'h09f8;
  localparam logic [15:0] HOST_CHANGE_OFS  = 16'h09fc;

  // ==========================================================================
  // Reset values and field layout
  localparam logic [63:0] TS_RESET      = 64'h0;
  localparam logic [31:0] EV_RESET      = 32'h0;
  localparam logic [55:0] TS_SHD_RESET  = 56'h0;
  localparam logic [23:0] EV_SHD_RESET  = 24'h0;
  localparam logic [2:0]  LOW_BYTE      = 3'h0;
  localparam int          SIDE_FB       = 0;
  localparam int          SIDE_HOST     = 1;
  localparam int          EV_FB_CHANGE  = 0;
  localparam int          EV_HOST_START = 1;
  localparam int          EV_HOST_CHG   = 2;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } access_s;

  typedef struct packed {
    logic       isLatch;
    logic       isEvent;
    logic [1:0] idx;
    logic [2:0] byteSel;
  } decode_s;

  // ==========================================================================
  // Address decode
  function automatic decode_s decodeAddr(input logic [15:0] addr);
    decode_s     d;
    logic [15:0] rel;
    d = '0;
    rel = addr - LATCH_A_RISE_OFS;
    if (addr >= LATCH_A_RISE_OFS && addr <= LATCH_LAST_OFS) begin
      d.isLatch = 1'b1;
      d.idx     = rel[4:3];
      d.byteSel = addr[2:0];
    end else if (addr[15:2] == FB_CHANGE_OFS[15:2]) begin
      d.isEvent = 1'b1;
      d.idx     = 2'(EV_FB_CHANGE);
      d.byteSel = {1'b0, addr[1:0]};
    end else if (addr[15:2] == HOST_START_OFS[15:2]) begin
      d.isEvent = 1'b1;
      d.idx     = 2'(EV_HOST_START);
      d.byteSel = {1'b0, addr[1:0]};
    end else if (addr[15:2] == HOST_CHANGE_OFS[15:2]) begin
      d.isEvent = 1'b1;
      d.idx     = 2'(EV_HOST_CHG);
      d.byteSel = {1'b0, addr[1:0]};
    end
    return d;
  endfunction

endpackage

// *** core/dc_latch_timestamp_capture.sv ***
// Latch input and buffer event timestamp capture with per-side shadows
`timescale 1ns/1ns
module dc_latch_timestamp_capture
  import dc_latch_pkg::*;
(
  input  wire  logic        ref_clk,
  input  wire  logic        reset_n,
  input  wire  logic        latchInputA,
  input  wire  logic        latchInputB,
  input  wire  logic [63:0] systemTime,
  input  wire  logic [31:0] localTime,
  input  wire  logic        frameStart,
  input  wire  logic        fbBufferEvent,
  input  wire  logic        hostStartEvent,
  input  wire  logic        hostChangeEvent,
  input  wire  logic [1:0]  latchModeA,
  input  wire  logic [1:0]  latchModeB,
  input  wire  logic        accessSelA,
  input  wire  logic        accessSelB,
  input  wire  logic        hostAckByWrite,
  input  wire  access_s     fieldbusAccess,
  input  wire  access_s     hostAccess,
  output logic [7:0]        fieldbusRdata,
  output logic [7:0]        hostRdata,
  output logic [2:0]        latchStatusA,
  output logic [2:0]        latchStatusB
);

  // ==========================================================================
  // State
  logic [1:0]  pinSync1;
  logic [1:0]  pinSync2;
  logic [1:0]  pinPrev;
  logic [63:0] stamp       [4];
  logic [3:0]  edgeFlag;
  logic [31:0] frameTime;
  logic [31:0] evTime      [3];
  logic [55:0] stampShadow [2][4];
  logic [23:0] evShadow    [2][3];
  logic [7:0]  rdata       [2];

  logic [1:0]  next_pinSync1;
  logic [1:0]  next_pinSync2;
  logic [1:0]  next_pinPrev;
  logic [63:0] next_stamp       [4];
  logic [3:0]  next_edgeFlag;
  logic [31:0] next_frameTime;
  logic [31:0] next_evTime      [3];
  logic [55:0] next_stampShadow [2][4];
  logic [23:0] next_evShadow    [2][3];
  logic [7:0]  next_rdata       [2];

  // ==========================================================================
  // Next state
  access_s    acc   [2];
  decode_s    dec   [2];
  logic [3:0] edgeSeen;
  logic [3:0] mode;
  logic [3:0] sel;
  logic [3:0] clr;
  logic [3:0] setF;
  logic [63:0] word;

  always_comb begin
    acc[SIDE_FB]   = fieldbusAccess;
    acc[SIDE_HOST] = hostAccess;
    for (int s = 0; s < 2; s++) begin
      dec[s] = decodeAddr(acc[s].addr);
    end
    next_pinSync1 = {latchInputB, latchInputA};
    next_pinSync2 = pinSync1;
    next_pinPrev  = pinSync2;
    // Index: 0 A rise, 1 A fall, 2 B rise, 3 B fall
    edgeSeen = {pinPrev[1] & ~pinSync2[1], ~pinPrev[1] & pinSync2[1],
                pinPrev[0] & ~pinSync2[0], ~pinPrev[0] & pinSync2[0]};
    mode = {latchModeB, latchModeA};
    sel  = {accessSelB, accessSelB, accessSelA, accessSelA};
    next_stamp = stamp;
    next_edgeFlag = edgeFlag;
    next_stampShadow = stampShadow;
    next_evShadow = evShadow;
    next_evTime = evTime;
    next_frameTime = frameTime;
    word = TS_RESET;
    // Writes never touch timestamp contents
    for (int k = 0; k < 4; k++) begin
      setF[k] = 1'b0;
      // Single mode holds the first edge until acknowledged
      if (edgeSeen[k] && !(mode[k] && edgeFlag[k])) begin
        next_stamp[k] = systemTime;
        setF[k] = mode[k];
      end
      clr[k] = 1'b0;
      if (dec[SIDE_FB].isLatch && dec[SIDE_FB].idx == 2'(k) &&
          acc[SIDE_FB].rd && dec[SIDE_FB].byteSel == LOW_BYTE &&
          !sel[k]) begin
        clr[k] = 1'b1;
      end
      if (dec[SIDE_HOST].isLatch && dec[SIDE_HOST].idx == 2'(k) && sel[k])
      begin
        if (hostAckByWrite) begin
          clr[k] = clr[k] | acc[SIDE_HOST].wr;
        end else begin
          clr[k] = clr[k] | (acc[SIDE_HOST].rd &&
                   dec[SIDE_HOST].byteSel == LOW_BYTE);
        end
      end
      // Set wins over clear; continuous mode reads zero
      next_edgeFlag[k] = mode[k] & (setF[k] | (edgeFlag[k] & ~clr[k]));
    end
    // Buffer event times
    if (frameStart) begin
      next_frameTime = localTime;
    end
    if (fbBufferEvent) begin
      next_evTime[EV_FB_CHANGE] = frameStart ? localTime : frameTime;
    end
    if (hostStartEvent) begin
      next_evTime[EV_HOST_START] = localTime;
    end
    if (hostChangeEvent) begin
      next_evTime[EV_HOST_CHG] = localTime;
    end
    // Read path with shadows
    for (int s = 0; s < 2; s++) begin
      next_rdata[s] = 8'h00;
      word = TS_RESET;
      if (dec[s].isLatch) begin
        if (dec[s].byteSel == LOW_BYTE) begin
          word = stamp[dec[s].idx];
          if (acc[s].rd) begin
            next_stampShadow[s][dec[s].idx] = stamp[dec[s].idx][63:8];
          end
        end else begin
          word = {stampShadow[s][dec[s].idx], 8'h00};
        end
      end else if (dec[s].isEvent && dec[s].idx <= 2'(EV_HOST_CHG) &&
                   (s == SIDE_HOST || dec[s].idx == 2'(EV_FB_CHANGE))) begin
        if (dec[s].byteSel == LOW_BYTE) begin
          word = {32'h0, evTime[dec[s].idx]};
          if (acc[s].rd) begin
            next_evShadow[s][dec[s].idx] = evTime[dec[s].idx][31:8];
          end
        end else begin
          word = {32'h0, evShadow[s][dec[s].idx], 8'h00};
        end
      end
      if (acc[s].rd) begin
        next_rdata[s] = word[{dec[s].byteSel, 3'b000} +: 8];
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinSync1  <= 2'h0;
      pinSync2  <= 2'h0;
      pinPrev   <= 2'h0;
      edgeFlag  <= 4'h0;
      frameTime <= EV_RESET;
      for (int k = 0; k < 4; k++) begin
        stamp[k] <= TS_RESET;
      end
      for (int e = 0; e < 3; e++) begin
        evTime[e] <= EV_RESET;
      end
      for (int s = 0; s < 2; s++) begin
        rdata[s] <= 8'h00;
        for (int k = 0; k < 4; k++) begin
          stampShadow[s][k] <= TS_SHD_RESET;
        end
        for (int e = 0; e < 3; e++) begin
          evShadow[s][e] <= EV_SHD_RESET;
        end
      end
    end else begin
      pinSync1    <= next_pinSync1;
      pinSync2    <= next_pinSync2;
      pinPrev     <= next_pinPrev;
      edgeFlag    <= next_edgeFlag;
      frameTime   <= next_frameTime;
      stamp       <= next_stamp;
      evTime      <= next_evTime;
      rdata       <= next_rdata;
      stampShadow <= next_stampShadow;
      evShadow    <= next_evShadow;
    end
  end

  // ==========================================================================
  // Outputs
  assign fieldbusRdata = rdata[SIDE_FB];
  assign hostRdata     = rdata[SIDE_HOST];
  assign latchStatusA  = {pinPrev[0], edgeFlag[1], edgeFlag[0]};
  assign latchStatusB  = {pinPrev[1], edgeFlag[3], edgeFlag[2]};

endmodule

// *** tb/dc_latch_sva.sv ***
// Assertion checker for the latch timestamp capture block
`timescale 1ns/1ns
module dc_latch_sva
  import dc_latch_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic [1:0] latchModeA,
  input wire logic [1:0] latchModeB,
  input wire logic       accessSelA,
  input wire logic       accessSelB,
  input wire logic       hostAckByWrite,
  input wire access_s    fieldbusAccess,
  input wire access_s    hostAccess,
  input wire logic [7:0] fieldbusRdata,
  input wire logic [7:0] hostRdata,
  input wire logic [2:0] latchStatusA,
  input wire logic [2:0] latchStatusB
);
  wire logic        fbRd = fieldbusAccess.rd;
  wire logic        hRd  = hostAccess.rd;
  wire logic        hWr  = hostAccess.wr;
  wire logic [15:0] fbAd = fieldbusAccess.addr;
  wire logic [15:0] hAd  = hostAccess.addr;
  // ========
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_fbIdle; !$past(fbRd) |-> fieldbusRdata == 8'h0; endproperty
  property p_hIdle; !$past(hRd) |-> hostRdata == 8'h0; endproperty
  property p_setA; $rose(latchStatusA[0]) |-> $past(latchModeA[0]); endproperty
  property p_holdA;
    latchStatusA[0] && latchModeA[0] && !fbRd && !hRd && !hWr
      |=> latchStatusA[0];
  endproperty
  property p_fbClrA;
    fbRd && fbAd == LATCH_A_RISE_OFS && !accessSelA |=> !latchStatusA[0];
  endproperty
  property p_fbClrB;
    fbRd && fbAd == LATCH_B_FALL_OFS && !accessSelB |=> !latchStatusB[1];
  endproperty
  property p_wrClrB;
    hWr && hostAckByWrite && accessSelB
      && hAd[15:3] == LATCH_B_RISE_OFS[15:3] |=> !latchStatusB[0];
  endproperty
  property p_noAckA;
    latchStatusA[1] && hWr && !hostAckByWrite && !fbRd |=> latchStatusA[1];
  endproperty
  property p_contB; !latchModeB[1] [*3] |-> !latchStatusB[1]; endproperty
  property p_hidden;
    fbRd && fbAd[15:3] == HOST_START_OFS[15:3] |=> fieldbusRdata == 8'h0;
  endproperty
  a_fbIdle: assert property (p_fbIdle) else $error("fb rdata");
  a_hIdle: assert property (p_hIdle) else $error("host rdata");
  a_setA: assert property (p_setA) else $error("flag set");
  a_holdA: assert property (p_holdA) else $error("flag hold");
  a_fbClrA: assert property (p_fbClrA) else $error("a clear");
  a_fbClrB: assert property (p_fbClrB) else $error("b clear");
  a_wrClrB: assert property (p_wrClrB) else $error("wr clear");
  a_noAckA: assert property (p_noAckA) else $error("no ack");
  a_contB: assert property (p_contB) else $error("cont flag");
  a_hidden: assert property (p_hidden) else $error("hidden");
  c_setA: cover property ($rose(latchStatusA[0]));
  c_clrB: cover property ($fell(latchStatusB[0]));
  c_hRd: cover property (hRd ##1 hostRdata != 8'h0);
endmodule
bind dc_latch_timestamp_capture dc_latch_sva u_dc_latch_sva (.*);

// *** tb/testbench.sv ***
// Self-checking bench for the latch timestamp capture block
`timescale 1ns/1ns
module testbench
  import dc_latch_pkg::*;
();
  logic        ref_clk = 1'b0, reset_n = 1'b0, run = 1'b0;
  logic        latchInputA = 1'b0, latchInputB = 1'b0, frameStart = 1'b0;
  logic        fbBufferEvent = 1'b0, hostStartEvent = 1'b0;
  logic        hostChangeEvent = 1'b0, hostAckByWrite = 1'b0;
  logic        accessSelA = 1'b0, accessSelB = 1'b0;
  logic        fbPend = 1'b0, hPend = 1'b0;
  logic [1:0]  latchModeA = 2'b11, latchModeB = 2'b11;
  logic [63:0] systemTime, seedTime, t1, t2, t4, t5;
  logic [31:0] localTime, l1, l4;
  logic [7:0]  fieldbusRdata, hostRdata, fbQ[$], hQ[$];
  logic [2:0]  latchStatusA, latchStatusB;
  access_s     fieldbusAccess = '0, hostAccess = '0;
  int          errCount = 0, checks = 0, seed = 32'h7562;

  dc_latch_timestamp_capture u_dc_latch_timestamp_capture (.*);
  time_base u_time_base (.*);

  // ========
  // Tasks
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [7:0] e, s);
    checks++;
    if (s !== e) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic idle();
    fieldbusAccess = '0;
    hostAccess = '0;
    tick(1);
  endtask
  task automatic acc(input bit h, w, input logic [15:0] a,
                     input logic [7:0] d);
    access_s x;
    x = '{addr: a, rd: !w, wr: w, wdata: d};
    if (h) hostAccess = x;
    else fieldbusAccess = x;
    tick(1);
  endtask
  task automatic rd(input bit h, input logic [15:0] a, input int n,
                    input logic [63:0] v);
    for (int i = 0; i < n; i++) begin
      if (h) hQ.push_back(v[8*(i%8)+:8]);
      else fbQ.push_back(v[8*(i%8)+:8]);
      acc(h, 1'b0, a + 16'(i), 8'h0);
    end
    idle();
  endtask
  task automatic pins(input logic a, b);
    latchInputA = a;
    latchInputB = b;
    tick(4);
  endtask
  task automatic adv();
    run = 1'b1;
    tick(3);
    run = 1'b0;
    tick(1);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  // ========
  // Clock, watchdog and read data monitor
  initial forever #50 ref_clk = ~ref_clk;
  initial begin
    #3000000;
    errCount++;
    wrapUp();
  end
  always @(posedge ref_clk) begin
    fbPend <= fieldbusAccess.rd;
    hPend  <= hostAccess.rd;
  end
  always @(negedge ref_clk) begin
    if (fbPend) cmp("fieldbusRdata", fbQ.pop_front(), fieldbusRdata);
    if (hPend) cmp("hostRdata", hQ.pop_front(), hostRdata);
  end

  // ========
  // Main sequence
  initial begin
    seedTime = {$random(seed), $random(seed)};
    repeat (6) @(posedge ref_clk);
    #2 reset_n = 1'b1;
    rd(0, LATCH_A_RISE_OFS, 32, 64'h0);
    rd(1, FB_CHANGE_OFS, 16, 64'h0);
    t1 = systemTime;
    pins(1, 1);
    adv();
    t2 = systemTime;
    pins(0, 0);
    adv();
    pins(1, 0);
    cmp("latchStatusA", 8'(latchStatusA), 8'h7);
    cmp("latchStatusB", 8'(latchStatusB), 8'h3);
    for (int i = 0; i < 32; i++)
      acc(0, 1'b1, LATCH_A_RISE_OFS + 16'(i), 8'($random(seed)));
    idle();
    rd(0, LATCH_A_RISE_OFS, 8, t1);
    rd(0, LATCH_B_FALL_OFS, 8, t2);
    cmp("latchStatusA", 8'(latchStatusA), 8'h6);
    cmp("latchStatusB", 8'(latchStatusB), 8'h1);
    accessSelA = 1'b1;
    accessSelB = 1'b1;
    acc(1, 1'b1, LATCH_A_FALL_OFS, 8'h0);
    rd(0, LATCH_A_FALL_OFS, 8, t2);
    cmp("latchStatusA", 8'(latchStatusA), 8'h6);
    rd(1, LATCH_A_FALL_OFS, 8, t2);
    cmp("latchStatusA", 8'(latchStatusA), 8'h4);
    hostAckByWrite = 1'b1;
    rd(1, LATCH_B_RISE_OFS, 8, t1);
    cmp("latchStatusB", 8'(latchStatusB), 8'h1);
    acc(1, 1'b1, LATCH_B_RISE_OFS + 16'h3, 8'h0);
    idle();
    cmp("latchStatusB", 8'(latchStatusB), 8'h0);
    rd(1, LATCH_B_RISE_OFS, 8, t1);
    latchModeA = 2'b00;
    latchModeB = 2'b00;
    adv();
    t4 = systemTime;
    pins(0, 1);
    rd(1, LATCH_A_FALL_OFS, 1, t4);
    adv();
    t5 = systemTime;
    pins(1, 0);
    pins(0, 0);
    rd(0, LATCH_A_FALL_OFS, 8, t5);
    rd(1, LATCH_A_FALL_OFS + 16'h1, 7, t4 >> 8);
    rd(0, LATCH_B_FALL_OFS, 8, t5);
    rd(0, LATCH_B_RISE_OFS, 8, t4);
    cmp("latchStatusA", 8'(latchStatusA), 8'h0);
    l1 = localTime;
    pulse(frameStart);
    adv();
    pulse(fbBufferEvent);
    l4 = localTime;
    pulse(hostStartEvent);
    pulse(hostChangeEvent);
    rd(0, FB_CHANGE_OFS, 4, 64'(l1));
    rd(1, FB_CHANGE_OFS, 4, 64'(l1));
    rd(1, HOST_START_OFS, 8, {l4, l4});
    rd(0, 16'h09f4, 12, 64'h0);
    rd(1, HOST_CHANGE_OFS, 1, 64'(l4));
    adv();
    pulse(hostChangeEvent);
    rd(1, HOST_CHANGE_OFS + 16'h1, 3, 64'(l4 >> 8));
    rd(1, HOST_CHANGE_OFS, 1, 64'(localTime));
    wrapUp();
  end
endmodule

// *** tb/time_base.sv ***
// Far-side time base model feeding system and local time
`timescale 1ns/1ns
module time_base (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        run,
  input  wire logic [63:0] seedTime,
  output logic [63:0]      systemTime,
  output logic [31:0]      localTime
);
  // Every byte steps so a stale shadow byte shows
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) systemTime <= seedTime;
    else if (run) systemTime <= systemTime + 64'h0101_0101_0101_0101;
  end
  assign localTime = systemTime[47:16] ^ 32'h5a5a_a5a5;
endmodule
